/* pfs_defines.svh */
// Purpose: Offsets, reset values and fixed figures of the program flow block.
// Assumes: Included by the package; the design module uses its macros.
// Notes:   Register offsets are indices on the plain register port.
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PFS_REG_PROG_COUNTER_LOW 3'h0
`define PFS_REG_TABLE_PTR_LOW 3'h1
`define PFS_REG_TABLE_PTR_HIGH 3'h2
`define PFS_REG_TABLE_HIGH_LATCH 3'h3
`define PFS_REG_BANK_SELECT 3'h4
`define PFS_REG_STATUS 3'h5

// ----------------------------------------------------------------------
// Widths and fixed addresses
// ----------------------------------------------------------------------
`define PFS_PM_ADDR_W 15
`define PFS_PM_DATA_W 16
`define PFS_INPAGE_W 13
`define PFS_BANK_W 2
`define PFS_PAGE_W 8
`define PFS_RESET_VECTOR 15'h0000
`define PFS_LAST_PAGE 7'h7f
`define PFS_PHASES 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PFS_RST_BYTE 8'h00
`define PFS_RST_PTR_HIGH 7'h00
`define PFS_RST_BANK 2'h0
`define PFS_RST_STATUS 4'h0

`endif

/* pfs_flow.sv */
// Purpose: Program counter, return stack and table read sequencing.
// Assumes: Decoder presents the operation of the executing instruction.
// Notes:   Program memory answers in the cycle of its read strobe.
`timescale 1ns/1ps

module pfs_flow
   import pfs_pkg::*;
#(
   parameter int STACK_DEPTH = 8,
   parameter int SECTOR_W = 3
) (
   // Clock, reset and enable
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Decoded instruction
   input wire pfs_op_e i_op,
   input wire logic [`PFS_INPAGE_W-1:0] i_target,
   input wire logic [SECTOR_W-1:0] i_op_sector,
   input wire logic [7:0] i_op_addr,
   input wire logic [7:0] i_alu_result,
   input wire logic [3:0] i_alu_flags,
   // Interrupt logic
   input wire logic i_int_req,
   input wire logic [`PFS_PM_ADDR_W-1:0] i_int_vector,
   output logic o_int_ack,
   // Program memory
   output logic [`PFS_PM_ADDR_W-1:0] o_pm_addr,
   output logic o_pm_rd,
   input wire logic [`PFS_PM_DATA_W-1:0] i_pm_rdata,
   // Data memory
   output logic o_dm_we,
   output logic [SECTOR_W+7:0] o_dm_addr,
   output logic [7:0] o_dm_wdata,
   // Register port
   input wire logic [2:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // Sequencing status
   output logic [1:0] o_phase,
   output logic o_discard,
   output logic o_hold
);

   localparam int SP_W = $clog2(STACK_DEPTH + 1);
   localparam logic [SP_W-1:0] SP_MAX = SP_W'(STACK_DEPTH);
   localparam int AW = `PFS_PM_ADDR_W;

   // ------------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------------
   if (STACK_DEPTH < 2 || STACK_DEPTH > 64) begin : g_bad_depth
      $error("Stack depth must lie between 2 and 64.");
   end
   if (SECTOR_W < 1 || SECTOR_W > 8) begin : g_bad_sector
      $error("Sector width must lie between 1 and 8.");
   end

   // ------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------
   function automatic logic is_table(input pfs_op_e op);
      is_table = (op == PFS_OP_PAGE_TABLE_READ) ||
                 (op == PFS_OP_LAST_PAGE_TABLE_READ) ||
                 (op == PFS_OP_EXT_PAGE_TABLE_READ) ||
                 (op == PFS_OP_EXT_LAST_PAGE_TABLE_READ);
   endfunction : is_table

   function automatic logic is_ctrl(input pfs_op_e op);
      is_ctrl = (op == PFS_OP_JUMP) || (op == PFS_OP_CALL) ||
                (op == PFS_OP_SUBROUTINE_EXIT) ||
                (op == PFS_OP_INTERRUPT_EXIT) || (op == PFS_OP_SKIP_MET);
   endfunction : is_ctrl

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   pfs_phase_e phase_r;
   pfs_phase_e phase_nxt;
   logic [AW-1:0] pc_r;
   logic [AW-1:0] pc_nxt;
   logic [AW-1:0] fetch_addr_r;
   logic [AW-1:0] stack_r [STACK_DEPTH];
   logic [SP_W-1:0] sp_r;
   logic dummy_r;
   logic dummy_nxt;
   logic tbl_busy_r;
   logic [AW-1:0] tbl_addr_r;
   logic [SECTOR_W+7:0] tbl_dest_r;
   logic pcl_pend_r;
   logic [7:0] pcl_val_r;
   logic [7:0] table_ptr_low_r;
   logic [6:0] table_ptr_high_r;
   logic [7:0] table_high_byte_latch_r;
   logic [`PFS_BANK_W-1:0] program_bank_select_r;
   logic [3:0] status_r;
   logic int_ack_r;
   logic [AW-1:0] pm_addr_r;
   logic pm_rd_r;
   logic dm_we_r;
   logic [SECTOR_W+7:0] dm_addr_r;
   logic [7:0] dm_wdata_r;
   logic [7:0] reg_rdata_r;
   logic boot_r;
   logic t4;
   logic op_go;
   logic pcl_apply;
   logic push;
   logic pop;
   logic ack_nxt;
   logic alu_wr;
   logic stack_full;

   assign o_int_ack = int_ack_r;
   assign o_pm_addr = pm_addr_r;
   assign o_pm_rd = pm_rd_r;
   assign o_dm_we = dm_we_r;
   assign o_dm_addr = dm_addr_r;
   assign o_dm_wdata = dm_wdata_r;
   assign o_reg_rdata = reg_rdata_r;
   assign o_phase = phase_r;
   assign o_discard = dummy_r;
   assign o_hold = tbl_busy_r;

   // ------------------------------------------------------------------
   // Phase generator
   // ------------------------------------------------------------------
   always_comb begin
      unique case (phase_r)
         PFS_T1: phase_nxt = PFS_T2;
         PFS_T2: phase_nxt = PFS_T3;
         PFS_T3: phase_nxt = PFS_T4;
         PFS_T4: phase_nxt = PFS_T1;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_r <= PFS_T1;
      end else if (i_ce) begin
         phase_r <= phase_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Operation control
   // ------------------------------------------------------------------
   assign stack_full = (sp_r == SP_MAX);
   assign t4 = i_ce && (phase_r == PFS_T4);
   assign op_go = t4 && !dummy_r && !tbl_busy_r;
   assign pcl_apply = t4 && pcl_pend_r && !tbl_busy_r;

   always_comb begin
      push = 1'b0;
      pop = 1'b0;
      ack_nxt = 1'b0;
      alu_wr = 1'b0;
      dummy_nxt = 1'b0;
      pc_nxt = pc_r;
      if (op_go) begin
         unique case (i_op)
            PFS_OP_JUMP: begin
               pc_nxt = {program_bank_select_r, i_target};
               dummy_nxt = 1'b1;
            end
            PFS_OP_CALL: begin
               push = 1'b1;
               pc_nxt = {program_bank_select_r, i_target};
               dummy_nxt = 1'b1;
            end
            PFS_OP_SUBROUTINE_EXIT, PFS_OP_INTERRUPT_EXIT: begin
               pop = 1'b1;
               pc_nxt = stack_r[0];
               dummy_nxt = 1'b1;
            end
            PFS_OP_SKIP_MET: begin
               dummy_nxt = 1'b1;
            end
            PFS_OP_ALU: begin
               alu_wr = 1'b1;
            end
            default: begin
            end
         endcase
         if (!is_ctrl(i_op) && !is_table(i_op) && !pcl_pend_r &&
             i_int_req && !stack_full) begin
            ack_nxt = 1'b1;
            push = 1'b1;
            pc_nxt = i_int_vector;
            dummy_nxt = 1'b1;
         end
      end
      if (pcl_apply) begin
         pc_nxt = {pc_r[AW-1:8], pcl_val_r};
         dummy_nxt = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Program counter and fetch
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pc_r <= `PFS_RESET_VECTOR;
         fetch_addr_r <= `PFS_RESET_VECTOR;
         pm_addr_r <= `PFS_RESET_VECTOR;
         pm_rd_r <= 1'b0;
         boot_r <= 1'b1;
      end else if (i_ce) begin
         pm_rd_r <= 1'b0;
         if (phase_r == PFS_T1 && !tbl_busy_r) begin
            pm_addr_r <= pc_r;
            pm_rd_r <= 1'b1;
            fetch_addr_r <= pc_r;
            pc_r <= pc_r + 15'h0001;
            boot_r <= 1'b0;
         end else if (phase_r == PFS_T2 && tbl_busy_r) begin
            pm_addr_r <= tbl_addr_r;
            pm_rd_r <= 1'b1;
         end else if (t4) begin
            pc_r <= pc_nxt;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dummy_r <= 1'b0;
         int_ack_r <= 1'b0;
      end else if (i_ce) begin
         int_ack_r <= ack_nxt;
         if (t4) begin
            dummy_r <= dummy_nxt;
         end
      end
   end

   // ------------------------------------------------------------------
   // Return stack
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sp_r <= '0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_r[i] <= `PFS_RESET_VECTOR;
         end
      end else if (i_ce) begin
         if (push) begin
            // The oldest entry drops off the bottom when full.
            for (int i = STACK_DEPTH - 1; i > 0; i--) begin
               stack_r[i] <= stack_r[i-1];
            end
            stack_r[0] <= fetch_addr_r;
            if (!stack_full) begin
               sp_r <= sp_r + 1'b1;
            end
         end else if (pop) begin
            for (int i = 0; i < STACK_DEPTH - 1; i++) begin
               stack_r[i] <= stack_r[i+1];
            end
            if (sp_r != '0) begin
               sp_r <= sp_r - 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Table read sequencing
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tbl_busy_r <= 1'b0;
         tbl_addr_r <= `PFS_RESET_VECTOR;
         tbl_dest_r <= '0;
      end else if (i_ce) begin
         if (op_go && is_table(i_op)) begin
            tbl_busy_r <= 1'b1;
            if (i_op == PFS_OP_LAST_PAGE_TABLE_READ ||
                i_op == PFS_OP_EXT_LAST_PAGE_TABLE_READ) begin
               tbl_addr_r <= {`PFS_LAST_PAGE, table_ptr_low_r};
            end else begin
               tbl_addr_r <= {table_ptr_high_r, table_ptr_low_r};
            end
            if (i_op == PFS_OP_PAGE_TABLE_READ ||
                i_op == PFS_OP_LAST_PAGE_TABLE_READ) begin
               tbl_dest_r <= {{SECTOR_W{1'b0}}, i_op_addr};
            end else begin
               tbl_dest_r <= {i_op_sector, i_op_addr};
            end
         end else if (t4) begin
            tbl_busy_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Data memory writes from table reads and the ALU
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dm_we_r <= 1'b0;
         dm_addr_r <= '0;
         dm_wdata_r <= `PFS_RST_BYTE;
      end else if (i_ce) begin
         dm_we_r <= 1'b0;
         if (tbl_busy_r && phase_r == PFS_T3) begin
            dm_we_r <= 1'b1;
            dm_addr_r <= tbl_dest_r;
            dm_wdata_r <= i_pm_rdata[7:0];
         end else if (alu_wr) begin
            dm_we_r <= 1'b1;
            dm_addr_r <= {i_op_sector, i_op_addr};
            dm_wdata_r <= i_alu_result;
         end
      end
   end

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pcl_pend_r <= 1'b0;
         pcl_val_r <= `PFS_RST_BYTE;
         table_ptr_low_r <= `PFS_RST_BYTE;
         table_ptr_high_r <= `PFS_RST_PTR_HIGH;
         table_high_byte_latch_r <= `PFS_RST_BYTE;
         program_bank_select_r <= `PFS_RST_BANK;
         status_r <= `PFS_RST_STATUS;
      end else if (i_ce) begin
         if (pcl_apply) begin
            pcl_pend_r <= 1'b0;
         end
         if (i_reg_wr) begin
            unique case (i_reg_addr)
               `PFS_REG_PROG_COUNTER_LOW: begin
                  pcl_pend_r <= 1'b1;
                  pcl_val_r <= i_reg_wdata;
               end
               `PFS_REG_TABLE_PTR_LOW: table_ptr_low_r <= i_reg_wdata;
               `PFS_REG_TABLE_PTR_HIGH: table_ptr_high_r <= i_reg_wdata[6:0];
               `PFS_REG_TABLE_HIGH_LATCH: begin
                  table_high_byte_latch_r <= i_reg_wdata;
               end
               `PFS_REG_BANK_SELECT: begin
                  program_bank_select_r <= i_reg_wdata[1:0];
               end
               `PFS_REG_STATUS: status_r <= i_reg_wdata[3:0];
               default: begin
               end
            endcase
         end
         if (tbl_busy_r && phase_r == PFS_T3) begin
            table_high_byte_latch_r <= i_pm_rdata[15:8];
         end
         if (alu_wr) begin
            status_r <= i_alu_flags;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         reg_rdata_r <= `PFS_RST_BYTE;
      end else if (i_ce) begin
         reg_rdata_r <= `PFS_RST_BYTE;
         if (i_reg_rd) begin
            unique case (i_reg_addr)
               `PFS_REG_PROG_COUNTER_LOW: reg_rdata_r <= fetch_addr_r[7:0];
               `PFS_REG_TABLE_PTR_LOW: reg_rdata_r <= table_ptr_low_r;
               `PFS_REG_TABLE_PTR_HIGH: reg_rdata_r <= {1'b0, table_ptr_high_r};
               `PFS_REG_TABLE_HIGH_LATCH: begin
                  reg_rdata_r <= table_high_byte_latch_r;
               end
               `PFS_REG_BANK_SELECT: begin
                  reg_rdata_r <= {6'h00, program_bank_select_r};
               end
               `PFS_REG_STATUS: reg_rdata_r <= {4'h0, status_r};
               default: reg_rdata_r <= `PFS_RST_BYTE;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n || !i_ce);

   sequence s_tbl_start;
      op_go && is_table(i_op);
   endsequence
   sequence s_tbl_run;
      tbl_busy_r [*4] ##1 !tbl_busy_r;
   endsequence
   sequence s_plain_tbl;
      op_go && (i_op == PFS_OP_PAGE_TABLE_READ ||
                i_op == PFS_OP_LAST_PAGE_TABLE_READ);
   endsequence

   a_reset_vector: assert property (
      (phase_r == PFS_T1 && boot_r) |=> (pm_rd_r && pm_addr_r == 15'h0000))
      else $error("First fetch after reset is not at address zero.");
   a_pcl_jump: assert property (
      pcl_apply |=> (pc_r[14:8] == $past(pc_r[14:8]) &&
                     pc_r[7:0] == $past(pcl_val_r) && dummy_r))
      else $error("Low byte jump left the page or skipped the dummy cycle.");
   a_call_push: assert property (
      (op_go && i_op == PFS_OP_CALL) |=>
         (stack_r[0] == $past(fetch_addr_r) &&
          sp_r == ($past(sp_r) == SP_MAX ? SP_MAX : $past(sp_r) + 1'b1)))
      else $error("Call did not push the counter correctly.");
   a_exit_pop: assert property (
      (op_go && !pcl_pend_r && (i_op == PFS_OP_SUBROUTINE_EXIT ||
       i_op == PFS_OP_INTERRUPT_EXIT)) |=> (pc_r == $past(stack_r[0])))
      else $error("Return did not reload the counter from the stack.");
   a_full_inhibit: assert property (
      (t4 && stack_full && i_int_req) |=> !int_ack_r)
      else $error("Interrupt acknowledged with the stack full.");
   a_ack_pushes: assert property (
      int_ack_r |-> ($past(sp_r) != SP_MAX && sp_r == $past(sp_r) + 1'b1))
      else $error("Acknowledge without a free stack level.");
   a_table_cycles: assert property (
      s_tbl_start |=> s_tbl_run)
      else $error("Table read did not span two instruction cycles.");
   a_table_sector: assert property (
      s_plain_tbl |-> ##4 (dm_we_r && dm_addr_r[SECTOR_W+7:8] == '0))
      else $error("Plain table read wrote outside sector zero.");
   a_table_bytes: assert property (
      (tbl_busy_r && phase_r == PFS_T3) |=>
         (table_high_byte_latch_r == $past(i_pm_rdata[15:8]) &&
          dm_wdata_r == $past(i_pm_rdata[7:0])))
      else $error("Table word bytes went to the wrong places.");
   a_alu_status: assert property (
      alu_wr |=> (dm_we_r && status_r == $past(i_alu_flags) &&
                  dm_wdata_r == $past(i_alu_result)))
      else $error("ALU result or status was not stored.");
   a_skip_dummy: assert property (
      (op_go && i_op == PFS_OP_SKIP_MET && !pcl_pend_r) |=>
         dummy_r [*4] ##1 !dummy_r)
      else $error("Met skip did not run exactly one dummy cycle.");

endmodule : pfs_flow

/* pfs_flow_test.sv */
// Purpose: Self-checking bench of the program flow block.
// Assumes: Memory model answers in the cycle of the read pulse.
// Notes:   Expected results wait in queues until they appear.
`timescale 1ns/1ps
module pfs_flow_test;
   import pfs_pkg::*;
   logic i_clock, i_rst_n, irq, wr, rd, rd_d, ack, pmrd, dmwe, disc, hold;
   pfs_op_e op;
   logic [12:0] tgt;
   logic [2:0] sec, ra;
   logic [7:0] oa, res, rw, rdat, lo, hi;
   logic [3:0] flg;
   logic [14:0] pma, last, a, s;
   logic [15:0] pmd, w;
   logic [10:0] dma;
   logic [7:0] dmd;
   logic [1:0] ph;
   logic [7:0] rq[$];
   logic [18:0] dq[$];
   int miscompares = 0, checked = 0, acks = 0, seed = 32'h2bf8;
   pfs_flow i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(1'b1),
      .i_op(op), .i_target(tgt), .i_op_sector(sec), .i_op_addr(oa),
      .i_alu_result(res), .i_alu_flags(flg), .i_int_req(irq),
      .i_int_vector(15'h0123), .o_int_ack(ack), .o_pm_addr(pma),
      .o_pm_rd(pmrd), .i_pm_rdata(pmd), .o_dm_we(dmwe), .o_dm_addr(dma),
      .o_dm_wdata(dmd), .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rdat), .o_phase(ph), .o_discard(disc),
      .o_hold(hold));
   pfs_pm_model i_pm (.i_clock(i_clock), .i_addr(pma), .i_rd(pmrd),
      .o_data(pmd));
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask : cmp
   task automatic stop_test;
      $display("miscompares %0d checked %0d", miscompares, checked);
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   task automatic acc(input logic wn, input logic [2:0] ad,
         input logic [7:0] d, input logic [7:0] e);
      if (!wn) begin
         rq.push_back(e);
      end
      wr <= wn;
      rd <= !wn;
      ra <= ad;
      rw <= d;
      @(posedge i_clock);
   endtask : acc
   task automatic do_op(input pfs_op_e o, input logic [12:0] t);
      wr <= 1'b0;
      rd <= 1'b0;
      do @(negedge i_clock); while (ph !== 2'd2 || disc || hold);
      @(posedge i_clock);
      op <= o;
      tgt <= t;
      oa <= $random(seed);
      sec <= $random(seed);
      res <= $random(seed);
      flg <= $random(seed);
      @(posedge i_clock);
      op <= PFS_OP_NONE;
   endtask : do_op
   task automatic fetch(output logic [14:0] f);
      do @(negedge i_clock); while (!(pmrd && !hold));
      f = pma;
      @(posedge i_clock);
   endtask : fetch
   always @(posedge i_clock) begin
      rd_d <= rd;
      if (ack) begin
         irq <= 1'b0;
      end
   end
   always @(negedge i_clock) begin
      if (pmrd && !hold) last <= pma;
      if (ack) acks++;
      if (rd_d) cmp(rdat, rq.pop_front());
      if (dmwe) cmp({dma, dmd}, dq.pop_front());
   end
   initial begin
      {i_rst_n, irq, wr, rd, rd_d, tgt, sec, ra, oa, res, rw, flg} = '0;
      op = PFS_OP_NONE;
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1'b1;
      fetch(a);
      cmp(a, 15'h0);
      acc(1'b1, 3'h3, 8'h5e, 8'h0);
      acc(1'b0, 3'h3, 8'h0, 8'h5e);
      acc(1'b1, 3'h7, 8'hff, 8'h0);
      acc(1'b0, 3'h7, 8'h0, 8'h0);
      for (int i = 0; i < 4; i++) begin
         lo = $random(seed);
         hi = $random(seed);
         acc(1'b1, 3'h1, lo, 8'h0);
         acc(1'b1, 3'h2, hi, 8'h0);
         do_op(pfs_op_e'(4'h7 + i[3:0]), 13'h0);
         w = {1'b0, i[0] ? 7'h7f : hi[6:0], lo} ^ 16'h3c96;
         dq.push_back({i[1] ? sec : 3'h0, oa, w[7:0]});
         repeat (6) @(posedge i_clock);
         acc(1'b0, 3'h3, 8'h0, w[15:8]);
      end
      do_op(PFS_OP_ALU, 13'h0);
      dq.push_back({sec, oa, res});
      repeat (2) @(posedge i_clock);
      acc(1'b0, 3'h5, 8'h0, {4'h0, flg});
      acc(1'b1, 3'h0, 8'h40, 8'h0);
      rd <= 1'b0;
      wr <= 1'b0;
      for (int i = 0; i < 4 && a[7:0] !== 8'h40; i++) fetch(a);
      cmp(a, 15'h0040);
      do_op(PFS_OP_CALL, 13'h1a5c);
      s = last;
      fetch(a);
      cmp(a, 15'h1a5c);
      do_op(PFS_OP_SUBROUTINE_EXIT, 13'h0);
      fetch(a);
      cmp(a, s);
      repeat (8) do_op(PFS_OP_CALL, 13'($random(seed)));
      irq <= 1'b1;
      repeat (16) @(posedge i_clock);
      cmp(acks, 0);
      do_op(PFS_OP_INTERRUPT_EXIT, 13'h0);
      repeat (16) @(posedge i_clock);
      cmp(acks, 1);
      stop_test();
   end
   initial begin
      #(8 * 20000);
      miscompares++;
      stop_test();
   end
endmodule : pfs_flow_test

/* pfs_pkg.sv */
// Purpose: Types shared by the program flow block.
// Assumes: Nothing beyond the defines header.
// Notes:   Operation codes are produced by the instruction decoder.
`include "pfs_defines.svh"

package pfs_pkg;

   // -------------------------------------------------------------------
   // Instruction cycle phases
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      PFS_T1 = 2'b00,
      PFS_T2 = 2'b01,
      PFS_T3 = 2'b10,
      PFS_T4 = 2'b11
   } pfs_phase_e;

   // -------------------------------------------------------------------
   // Decoded operations
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      PFS_OP_NONE = 4'h0,
      PFS_OP_ALU = 4'h1,
      PFS_OP_JUMP = 4'h2,
      PFS_OP_CALL = 4'h3,
      PFS_OP_SUBROUTINE_EXIT = 4'h4,
      PFS_OP_INTERRUPT_EXIT = 4'h5,
      PFS_OP_SKIP_MET = 4'h6,
      PFS_OP_PAGE_TABLE_READ = 4'h7,
      PFS_OP_LAST_PAGE_TABLE_READ = 4'h8,
      PFS_OP_EXT_PAGE_TABLE_READ = 4'h9,
      PFS_OP_EXT_LAST_PAGE_TABLE_READ = 4'ha
   } pfs_op_e;

endpackage : pfs_pkg

/* pfs_pm_model.sv */
// Purpose: Program memory at the far side of the program flow block.
// Assumes: Each word is a fixed function of its address.
// Notes:   Outside a read the data lines show a changing pattern.
`timescale 1ns/1ps
module pfs_pm_model (
   // Clock
   input wire logic i_clock,
   // Memory port
   input wire logic [14:0] i_addr,
   input wire logic i_rd,
   output logic [15:0] o_data
);
   logic [15:0] junk_r = 16'h0;
   always @(posedge i_clock) begin
      junk_r <= ~junk_r ^ 16'h1234;
   end
   assign o_data = i_rd ? ({1'b0, i_addr} ^ 16'h3c96) : junk_r;
endmodule : pfs_pm_model
